// *** inc/abs_cfg.svh ***
// Constants for the auto buffer serial port: register indexes, reset
// values, clock select codes and serial timing counts.
// Assumes a 125 MHz system clock and word-per-register AXI4-Lite access.
`ifndef ABS_CFG_SVH
`define ABS_CFG_SVH

// Register indexes; byte address is four times the index
`define ABS_IDX_MODE 16'hFF63
`define ABS_IDX_CTRL 16'hFF64
`define ABS_IDX_INTV 16'hFF65
`define ABS_IDX_SHIFT 16'hFF66
`define ABS_IDX_PTR 16'hFF67
`define ABS_IDX_RAM_LO 16'hF9C0
`define ABS_IDX_RAM_HI 16'hF9DF
`define ABS_AW 18

`define ABS_MODE_RST 8'h00
`define ABS_CTRL_RST 8'h00
`define ABS_INTV_RST 8'h00
`define ABS_PTR_RST 5'h00
`define ABS_BYTE_ZERO 8'h00

// Clock select codes
`define ABS_CLK_EXT 2'h0
`define ABS_CLK_DIV4 2'h1
`define ABS_CLK_DIV8 2'h2

// Half serial periods in system clocks for divide by 4, 8, 16
`define ABS_HALF_DIV4 4'h2
`define ABS_HALF_DIV8 4'h4
`define ABS_HALF_DIV16 4'h8

// Gaps counted in half serial periods
`define ABS_GAP_FIXED 7'h04
`define ABS_GAP_N0 7'h05
`define ABS_GAP_BASE 7'h03
`define ABS_END_HALVES 7'h04

`define ABS_LAST_BIT 3'h7
`define ABS_PTR_LAST 5'h00
`define ABS_RESP_OKAY 2'h0
`define ABS_RESP_SLVERR 2'h2

`endif

// *** inc/abs_pkg.sv ***
// Types for the auto buffer serial port: register layouts, pin group
// and engine states. Needs nothing from its surroundings.
package abs_pkg;

	typedef struct packed {
		logic enable;
		logic lsb_first;
		logic auto_mode;
		logic clk_idle_high;
		logic [1:0] rsvd;
		logic [1:0] clk_sel;
	} abs_mode_type;

	typedef struct packed {
		logic rx_on;
		logic repeat_rsvd;
		logic rsvd5;
		logic fault;
		logic active;
		logic rsvd2;
		logic handshake;
		logic rsvd0;
	} abs_ctrl_type;

	typedef struct packed {
		logic ctrl_en;
		logic [1:0] rsvd;
		logic [4:0] count;
	} abs_intv_type;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic so_o;
		logic so_oe;
		logic busy_serial;
		logic si_serial;
	} abs_pins_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_LOADW,
		ST_SHIFT,
		ST_STORE,
		ST_GAP,
		ST_END
	} abs_state_type;

endpackage : abs_pkg

// *** rtl/abs_ram.sv ***
// Buffer RAM of 32 bytes for the auto buffer serial port.
// Single port; the caller arbitrates; read data comes from a register.
`timescale 1ns/1ps
module abs_ram (
	input wire logic clock_in,
	input wire logic en_in,
	input wire logic we_in,
	input wire logic [4:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [0:31];

	// No reset on contents or on the read register
	always_ff @(posedge clock_in) begin
		if (en_in && we_in)
			mem[addr_in] <= wdata_in;
		if (en_in && !we_in)
			rdata_out <= mem[addr_in];
	end
endmodule : abs_ram

// *** rtl/abs_top.sv ***
// Auto buffer serial port: three-wire serial engine with AXI4-Lite
// registers and a 32-byte buffer RAM.
// Assumes pins arrive asynchronous; port-side latches on clock_in.
`timescale 1ns/1ps
`include "abs_cfg.svh"
module abs_top (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic [`ABS_AW-1:0] axi_awaddr_in,
	input wire logic axi_awvalid_in,
	output logic axi_awready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic [3:0] axi_wstrb_in,
	input wire logic axi_wvalid_in,
	output logic axi_wready_out,
	output logic [1:0] axi_bresp_out,
	output logic axi_bvalid_out,
	input wire logic axi_bready_in,
	input wire logic [`ABS_AW-1:0] axi_araddr_in,
	input wire logic axi_arvalid_in,
	output logic axi_arready_out,
	output logic [31:0] axi_rdata_out,
	output logic [1:0] axi_rresp_out,
	output logic axi_rvalid_out,
	input wire logic axi_rready_in,
	input wire logic serial_clock_pin_in,
	input wire logic serial_in_pin_in,
	input wire logic handshake_port_pin_in,
	input wire logic clock_port_out_in,
	input wire logic clock_port_oe_in,
	input wire logic so_port_out_in,
	input wire logic so_port_oe_in,
	input wire logic irq_ack_in,
	output abs_pkg::abs_pins_type pins_out,
	output logic transfer_done_request_out
);
	import abs_pkg::*;

	function automatic [7:0] rev8(input [7:0] d, input flip);
		integer i;
		rev8 = d;
		if (flip)
			for (i = 0; i < 8; i = i + 1)
				rev8[i] = d[7 - i];
	endfunction : rev8

	function automatic [3:0] half_len(input [1:0] sel);
		if (sel == `ABS_CLK_DIV4)
			half_len = `ABS_HALF_DIV4;
		else if (sel == `ABS_CLK_DIV8)
			half_len = `ABS_HALF_DIV8;
		else
			half_len = `ABS_HALF_DIV16;
	endfunction : half_len

	function automatic hit(input [`ABS_AW-1:0] a, input [15:0] idx);
		hit = (a[`ABS_AW-1:2] == idx);
	endfunction : hit

	function automatic in_ram(input [`ABS_AW-1:0] a);
		in_ram = (a[`ABS_AW-1:2] >= `ABS_IDX_RAM_LO) &&
			(a[`ABS_AW-1:2] <= `ABS_IDX_RAM_HI);
	endfunction : in_ram

	abs_mode_type mode_reg;
	abs_ctrl_type ctrl_reg;
	abs_intv_type intv_reg;
	abs_state_type state_reg;
	logic [4:0] ptr_reg;
	logic [7:0] sh_reg, rx_reg;
	logic cap1_reg, cap2_reg;
	logic so_reg, sck_reg, done_reg;
	logic [2:0] bit_reg;
	logic [3:0] half_reg;
	logic [6:0] gap_reg;
	logic sck_s1, sck_s2, sck_s3, si_s1, si_s2, busy_s1, busy_s2;

	// Bus slave holding state
	logic aw_hold_reg, w_hold_reg;
	logic [`ABS_AW-1:0] awaddr_reg, araddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb_reg;
	logic rd1_reg, rd2_reg;
	logic [7:0] ram_rdata;

	wire aw_taken = axi_awvalid_in && axi_awready_out;
	wire w_taken = axi_wvalid_in && axi_wready_out;
	wire ar_taken = axi_arvalid_in && axi_arready_out;
	wire b_done = axi_bvalid_out && axi_bready_in;
	wire r_done = axi_rvalid_out && axi_rready_in;
	wire wr_exec = aw_hold_reg && w_hold_reg && !axi_bvalid_out;
	wire wr_en = wr_exec && wstrb_reg;
	wire wr_mode = wr_en && hit(awaddr_reg, `ABS_IDX_MODE);
	wire wr_ctrl = wr_en && hit(awaddr_reg, `ABS_IDX_CTRL);
	wire wr_intv = wr_en && hit(awaddr_reg, `ABS_IDX_INTV);
	wire wr_shift = wr_en && hit(awaddr_reg, `ABS_IDX_SHIFT);
	wire wr_ptr = wr_en && hit(awaddr_reg, `ABS_IDX_PTR);
	wire wr_ram = wr_en && in_ram(awaddr_reg);
	wire wr_mapped = in_ram(awaddr_reg) || hit(awaddr_reg, `ABS_IDX_MODE) ||
		hit(awaddr_reg, `ABS_IDX_CTRL) || hit(awaddr_reg, `ABS_IDX_INTV) ||
		hit(awaddr_reg, `ABS_IDX_SHIFT) || hit(awaddr_reg, `ABS_IDX_PTR);
	wire rd_ram = rd1_reg && in_ram(araddr_reg);
	wire rd_mapped = in_ram(araddr_reg) || hit(araddr_reg, `ABS_IDX_MODE) ||
		hit(araddr_reg, `ABS_IDX_CTRL) || hit(araddr_reg, `ABS_IDX_INTV) ||
		hit(araddr_reg, `ABS_IDX_SHIFT) || hit(araddr_reg, `ABS_IDX_PTR);

	// processor wins RAM
	// Bus access takes the port first; engine waits, so gaps stretch
	wire bus_ram = wr_ram || rd_ram;
	// Store waits for the delayed capture of the last bit
	wire eng_store = (state_reg == ST_STORE) && !bus_ram &&
		!cap1_reg && !cap2_reg;
	wire eng_load = (state_reg == ST_LOAD) && !bus_ram;
	wire ram_en = bus_ram || (eng_store && ctrl_reg.rx_on) || eng_load;
	wire ram_we = wr_ram || (!rd_ram && eng_store);
	wire [4:0] ram_addr = wr_ram ? awaddr_reg[6:2] :
		(rd_ram ? araddr_reg[6:2] : ptr_reg);
	wire [7:0] ram_wdata = wr_ram ? wdata_reg :
		rev8(rx_reg, mode_reg.lsb_first);

	abs_ram u_ram (
		.clock_in(clock_in),
		.en_in(ram_en),
		.we_in(ram_we),
		.addr_in(ram_addr),
		.wdata_in(ram_wdata),
		.rdata_out(ram_rdata)
	);

	wire master = (mode_reg.clk_sel != `ABS_CLK_EXT);
	// Divider runs through the store so gap and end count from last rise
	wire div_run = master && ((state_reg == ST_SHIFT) ||
		(state_reg == ST_STORE) || (state_reg == ST_GAP) ||
		(state_reg == ST_END));
	wire tick = div_run && (half_reg == half_len(mode_reg.clk_sel) - 4'h1);
	wire ext_rise = sck_s2 && !sck_s3;
	wire ext_fall = !sck_s2 && sck_s3;
	wire in_shift = (state_reg == ST_SHIFT);
	wire fall = in_shift && (master ? (tick && sck_reg) : ext_fall);
	wire rise = in_shift && (master ? (tick && !sck_reg) : ext_rise);
	wire byte_end = rise && (bit_reg == `ABS_LAST_BIT);

	wire [6:0] gap_len = !intv_reg.ctrl_en ? `ABS_GAP_FIXED :
		(intv_reg.count == 5'h00) ? `ABS_GAP_N0 :
		{1'b0, intv_reg.count, 1'b0} + `ABS_GAP_BASE;
	wire gap_done = !master || (tick && (gap_reg >= gap_len - 7'h01));
	wire end_done = master ?
		(tick && (gap_reg >= `ABS_END_HALVES - 7'h01)) : ext_rise;
	wire hs_wait = ctrl_reg.handshake && !intv_reg.ctrl_en && busy_s2;
	wire seq_done = (state_reg == ST_END) && end_done;
	wire plain_done = byte_end && !mode_reg.auto_mode;
	wire start = wr_shift && mode_reg.enable && (state_reg == ST_IDLE);

	// Pin synchronisers
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{sck_s1, sck_s2, sck_s3} <= 3'h7;
			{si_s1, si_s2, busy_s1, busy_s2} <= 4'h0;
		end else begin
			{sck_s1, sck_s2, sck_s3} <= {serial_clock_pin_in, sck_s1, sck_s2};
			{si_s1, si_s2} <= {serial_in_pin_in, si_s1};
			{busy_s1, busy_s2} <= {handshake_port_pin_in, busy_s1};
		end
	end

	// Software registers
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_reg <= `ABS_MODE_RST;
			intv_reg <= `ABS_INTV_RST;
			ctrl_reg <= `ABS_CTRL_RST;
		end else begin
			if (wr_mode)
				mode_reg <= {wdata_reg[7:4], 2'h0, wdata_reg[1:0]};
			if (wr_intv)
				intv_reg <= {wdata_reg[7], 2'h0, wdata_reg[4:0]};
			if (wr_ctrl) begin
				ctrl_reg.rx_on <= wdata_reg[7];
				ctrl_reg.handshake <= wdata_reg[1];
			end
			if (!mode_reg.enable || seq_done)
				ctrl_reg.active <= 1'b0;
			else if (start && mode_reg.auto_mode)
				ctrl_reg.active <= 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			done_reg <= 1'b0;
		else if (seq_done || plain_done)
			done_reg <= 1'b1;
		else if (irq_ack_in)
			done_reg <= 1'b0;
	end

	// Divider, serial clock and gap counters
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			half_reg <= 4'h0;
			sck_reg <= 1'b1;
			gap_reg <= 7'h00;
			cap1_reg <= 1'b0;
			cap2_reg <= 1'b0;
		end else begin
			cap1_reg <= rise;
			cap2_reg <= cap1_reg;
			half_reg <= (!div_run || tick) ? 4'h0 : half_reg + 4'h1;
			if (!in_shift)
				sck_reg <= 1'b1;
			else if (tick)
				sck_reg <= !sck_reg;
			if ((state_reg != ST_STORE) && (state_reg != ST_GAP) &&
				(state_reg != ST_END))
				gap_reg <= 7'h00;
			else if (tick)
				gap_reg <= gap_reg + 7'h01;
		end
	end

	// Engine state and shift path
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= ST_IDLE;
			sh_reg <= `ABS_BYTE_ZERO;
			rx_reg <= `ABS_BYTE_ZERO;
			so_reg <= 1'b0;
			bit_reg <= 3'h0;
			ptr_reg <= `ABS_PTR_RST;
		end else if (!mode_reg.enable) begin
			state_reg <= ST_IDLE;
			bit_reg <= 3'h0;
			so_reg <= 1'b0;
			if (wr_shift) begin
				sh_reg <= rev8(wdata_reg, mode_reg.lsb_first);
				rx_reg <= rev8(wdata_reg, mode_reg.lsb_first);
			end
			if (wr_ptr)
				ptr_reg <= wdata_reg[4:0];
		end else begin
			if (wr_ptr && (state_reg == ST_IDLE))
				ptr_reg <= wdata_reg[4:0];
			// zeros shift in when receive off
			// Two cycles late: pin register plus synchroniser delay
			if (cap2_reg)
				rx_reg <= {rx_reg[6:0], ctrl_reg.rx_on && si_s2};
			case (state_reg)
				ST_IDLE: begin
					// write triggers in auto and plain mode; auto loads from RAM first
					if (start) begin
						so_reg <= 1'b0;
						bit_reg <= 3'h0;
						if (mode_reg.auto_mode) begin
							state_reg <= ST_LOAD;
						end else begin
							sh_reg <= rev8(wdata_reg, mode_reg.lsb_first);
							state_reg <= ST_SHIFT;
						end
					end
				end
				ST_LOAD: begin
					if (eng_load)
						state_reg <= ST_LOADW;
				end
				ST_LOADW: begin
					sh_reg <= rev8(ram_rdata, mode_reg.lsb_first);
					if (!hs_wait)
						state_reg <= ST_SHIFT;
					else
						state_reg <= ST_LOAD;
				end
				ST_SHIFT: begin
					if (fall) begin
						so_reg <= sh_reg[7];
						sh_reg <= {sh_reg[6:0], 1'b0};
					end
					if (rise)
						bit_reg <= bit_reg + 3'h1;
					if (byte_end)
						state_reg <= mode_reg.auto_mode ? ST_STORE : ST_IDLE;
				end
				ST_STORE: begin
					if (eng_store) begin
						if (ptr_reg == `ABS_PTR_LAST) begin
							state_reg <= ST_END;
						end else begin
							ptr_reg <= ptr_reg - 5'h01;
							state_reg <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					if (gap_done)
						state_reg <= ST_LOAD;
				end
				ST_END: begin
					if (end_done) begin
						so_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pins_out <= '0;
			transfer_done_request_out <= 1'b0;
		end else begin
			transfer_done_request_out <= done_reg;
			if (mode_reg.enable) begin
				pins_out.sck_o <= sck_reg;
				pins_out.sck_oe <= master;
				pins_out.so_o <= so_reg;
				pins_out.so_oe <= 1'b1;
			end else begin
				pins_out.sck_o <= mode_reg.clk_idle_high | clock_port_out_in;
				pins_out.sck_oe <= mode_reg.clk_idle_high | clock_port_oe_in;
				pins_out.so_o <= so_port_out_in;
				pins_out.so_oe <= so_port_oe_in;
			end
			pins_out.busy_serial <= mode_reg.enable && ctrl_reg.handshake;
			pins_out.si_serial <= mode_reg.enable && ctrl_reg.rx_on;
		end
	end

	// Read data select, valid in second read cycle
	wire [7:0] rd_byte = in_ram(araddr_reg) ? ram_rdata :
		hit(araddr_reg, `ABS_IDX_MODE) ? mode_reg :
		hit(araddr_reg, `ABS_IDX_CTRL) ? ctrl_reg :
		hit(araddr_reg, `ABS_IDX_INTV) ? intv_reg :
		hit(araddr_reg, `ABS_IDX_SHIFT) ? rev8(rx_reg, mode_reg.lsb_first) :
		hit(araddr_reg, `ABS_IDX_PTR) ? {3'h0, ptr_reg} : `ABS_BYTE_ZERO;

	// AXI4-Lite write channel
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			axi_awready_out <= 1'b1;
			axi_wready_out <= 1'b1;
			axi_bvalid_out <= 1'b0;
			axi_bresp_out <= `ABS_RESP_OKAY;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= `ABS_BYTE_ZERO;
			wstrb_reg <= 1'b0;
		end else begin
			if (aw_taken) begin
				axi_awready_out <= 1'b0;
				aw_hold_reg <= 1'b1;
				awaddr_reg <= axi_awaddr_in;
			end else if (b_done) begin
				axi_awready_out <= 1'b1;
			end
			if (w_taken) begin
				axi_wready_out <= 1'b0;
				w_hold_reg <= 1'b1;
				wdata_reg <= axi_wdata_in[7:0];
				wstrb_reg <= axi_wstrb_in[0];
			end else if (b_done) begin
				axi_wready_out <= 1'b1;
			end
			if (wr_exec) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				axi_bvalid_out <= 1'b1;
				axi_bresp_out <= wr_mapped ? `ABS_RESP_OKAY : `ABS_RESP_SLVERR;
			end else if (b_done) begin
				axi_bvalid_out <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			axi_arready_out <= 1'b1;
			axi_rvalid_out <= 1'b0;
			axi_rdata_out <= 32'h00000000;
			axi_rresp_out <= `ABS_RESP_OKAY;
			araddr_reg <= '0;
			rd1_reg <= 1'b0;
			rd2_reg <= 1'b0;
		end else begin
			rd1_reg <= ar_taken;
			rd2_reg <= rd1_reg;
			if (ar_taken) begin
				axi_arready_out <= 1'b0;
				araddr_reg <= axi_araddr_in;
			end else if (r_done) begin
				axi_arready_out <= 1'b1;
			end
			if (rd2_reg) begin
				axi_rvalid_out <= 1'b1;
				axi_rdata_out <= {24'h000000, rd_byte};
				axi_rresp_out <= rd_mapped ? `ABS_RESP_OKAY : `ABS_RESP_SLVERR;
			end else if (r_done) begin
				axi_rvalid_out <= 1'b0;
			end
		end
	end
endmodule : abs_top

// *** tb/abs_chk.sv ***
// Checker for the auto buffer serial port top, bound to abs_top.
// Assumes writes offer address and data together, as the bench does.
`timescale 1ns/1ps
`include "abs_cfg.svh"
module abs_chk (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic [`ABS_AW-1:0] axi_awaddr_in,
	input wire logic axi_awvalid_in,
	input wire logic axi_awready_out,
	input wire logic [31:0] axi_wdata_in,
	input wire logic axi_bvalid_out,
	input wire logic axi_bready_in,
	input wire logic clock_port_out_in,
	input wire logic clock_port_oe_in,
	input wire logic so_port_out_in,
	input wire logic so_port_oe_in,
	input wire logic irq_ack_in,
	input wire abs_pkg::abs_pins_type pins_out,
	input wire logic transfer_done_request_out
);
	import abs_pkg::*;
	logic [15:0] idx_reg;
	logic [7:0] data_reg;
	abs_mode_type mode_reg;
	abs_ctrl_type ctrl_reg;
	logic aw_reg;
	// Shadow lags the design until the write response; skip that window
	wire quiet = axi_awready_out && aw_reg;
	wire idle = quiet && !mode_reg.enable;
	wire run4 = quiet && mode_reg.enable && mode_reg.clk_sel == 2'h1;
	wire run16 = quiet && mode_reg.enable && mode_reg.clk_sel == 2'h3;
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			idx_reg <= 16'h0000;
			data_reg <= 8'h00;
			mode_reg <= 8'h00;
			ctrl_reg <= 8'h00;
			aw_reg <= 1'b0;
		end else begin
			aw_reg <= axi_awready_out;
			if (axi_awvalid_in && axi_awready_out) begin
				idx_reg <= axi_awaddr_in[17:2];
				data_reg <= axi_wdata_in[7:0];
			end
			if (axi_bvalid_out && axi_bready_in && idx_reg == `ABS_IDX_MODE)
				mode_reg <= data_reg;
			if (axi_bvalid_out && axi_bready_in && idx_reg == `ABS_IDX_CTRL)
				ctrl_reg <= data_reg;
		end
	end
	sequence s_low2;
		!pins_out.sck_o ##1 pins_out.sck_o;
	endsequence
	sequence s_low8;
		!pins_out.sck_o [*7] ##1 pins_out.sck_o;
	endsequence
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	a_off_port_pass: assert property (
		idle && !mode_reg.clk_idle_high |->
		pins_out.sck_o == $past(clock_port_out_in) &&
		pins_out.sck_oe == $past(clock_port_oe_in) &&
		pins_out.so_o == $past(so_port_out_in) &&
		pins_out.so_oe == $past(so_port_oe_in) && !pins_out.busy_serial)
		else $error("port pass lost");
	a_off_sck_high: assert property (
		idle && mode_reg.clk_idle_high |-> pins_out.sck_o && pins_out.sck_oe)
		else $error("idle clock not high");
	a_ext_no_drive: assert property (
		quiet && mode_reg.enable && mode_reg.clk_sel == 2'h0
		|-> !pins_out.sck_oe) else $error("clock driven in slave");
	a_div4_half: assert property (
		run4 && $fell(pins_out.sck_o) |=> s_low2)
		else $error("divide 4 half wrong");
	a_div16_half: assert property (
		run16 && $fell(pins_out.sck_o) |=> s_low8)
		else $error("divide 16 half wrong");
	a_busy_port: assert property (
		quiet && !ctrl_reg.handshake |-> !pins_out.busy_serial)
		else $error("busy pin taken");
	a_rx_port: assert property (
		quiet && !ctrl_reg.rx_on |-> !pins_out.si_serial)
		else $error("input pin taken");
	a_so_on_fall: assert property (
		run4 && $rose(pins_out.so_o) |-> $fell(pins_out.sck_o))
		else $error("data moved off falling edge");
	a_end_so_low: assert property (
		quiet && mode_reg.enable && mode_reg.auto_mode &&
		$rose(transfer_done_request_out) |-> !pins_out.so_o)
		else $error("data not low at end");
	a_ack_clears: assert property (
		transfer_done_request_out && irq_ack_in
		|-> ##2 !transfer_done_request_out) else $error("ack ignored");
	a_done_holds: assert property (
		transfer_done_request_out && !irq_ack_in && !$past(irq_ack_in)
		|=> transfer_done_request_out) else $error("done dropped");
endmodule : abs_chk

bind abs_top abs_chk u_chk (
	.clock_in(clock_in),
	.nrst_in(nrst_in),
	.axi_awaddr_in(axi_awaddr_in),
	.axi_awvalid_in(axi_awvalid_in),
	.axi_awready_out(axi_awready_out),
	.axi_wdata_in(axi_wdata_in),
	.axi_bvalid_out(axi_bvalid_out),
	.axi_bready_in(axi_bready_in),
	.clock_port_out_in(clock_port_out_in),
	.clock_port_oe_in(clock_port_oe_in),
	.so_port_out_in(so_port_out_in),
	.so_port_oe_in(so_port_oe_in),
	.irq_ack_in(irq_ack_in),
	.pins_out(pins_out),
	.transfer_done_request_out(transfer_done_request_out)
);

// *** tb/abs_periph.sv ***
// Serial peripheral on the far side of the three wires.
// Assumes a clock wire that idles high; logs bytes and high stretches.
`timescale 1ns/1ps
module abs_periph (
	input wire logic sck_in,
	input wire logic so_in,
	output logic si_out
);
	logic [7:0] rx_reg;
	logic [7:0] tx_reg;
	int bits;
	int k;
	longint t_rise;
	logic [7:0] got[$];
	longint highs[$];
	initial begin
		si_out = 1'b0;
		bits = 0;
		k = 0;
		t_rise = 0;
	end
	always @(negedge sck_in) begin
		highs.push_back($time - t_rise);
		if (bits == 0)
			tx_reg = 8'h1E + 8'(k);
		si_out = tx_reg[7 - bits];
	end
	always @(posedge sck_in) begin
		t_rise = $time;
		rx_reg = {rx_reg[6:0], so_in};
		bits++;
		if (bits == 8) begin
			got.push_back(rx_reg);
			k++;
			bits = 0;
			// Released line must not keep the last bit
			#4 si_out = ~si_out;
		end
	end
endmodule : abs_periph

// *** tb/abs_top_bench.sv ***
// Self-checking bench for the auto buffer serial port over AXI4-Lite.
// Assumes abs_chk is bound in and abs_periph sits on the serial wires.
`timescale 1ns/1ps
`include "abs_cfg.svh"
module abs_top_bench;
	import abs_pkg::*;
	localparam logic [17:0] A_MODE = {`ABS_IDX_MODE, 2'b00};
	localparam logic [17:0] A_CTRL = {`ABS_IDX_CTRL, 2'b00};
	localparam logic [17:0] A_INTV = {`ABS_IDX_INTV, 2'b00};
	localparam logic [17:0] A_SHIFT = {`ABS_IDX_SHIFT, 2'b00};
	localparam logic [17:0] A_PTR = {`ABS_IDX_PTR, 2'b00};
	localparam logic [17:0] A_RAM = {`ABS_IDX_RAM_LO, 2'b00};
	logic clock_in, nrst_in, awvalid, wvalid, bready, arvalid, rready;
	logic irq_ack, busy;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rd_data;
	logic [1:0] rd_resp, wr_resp;
	logic [3:0] port_cnt;
	wire awready, wready, bvalid, arready, rvalid, done, si;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	abs_pins_type pins;
	wire sck_w = pins.sck_oe ? pins.sck_o : 1'b1;
	wire so_w = pins.so_oe ? pins.so_o : 1'b1;
	int miscompares, tests_run;
	longint base;
	logic [7:0] intv_tab [4] = '{8'h80, 8'h85, 8'h9F, 8'h85};
	int xtra [4] = '{1, 9, 61, 9};
	abs_top DUT (.clock_in(clock_in), .nrst_in(nrst_in),
		.axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
		.axi_awready_out(awready), .axi_wdata_in(wdata),
		.axi_wstrb_in(4'hF), .axi_wvalid_in(wvalid),
		.axi_wready_out(wready), .axi_bresp_out(bresp),
		.axi_bvalid_out(bvalid), .axi_bready_in(bready),
		.axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
		.axi_arready_out(arready), .axi_rdata_out(rdata),
		.axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
		.axi_rready_in(rready), .serial_clock_pin_in(sck_w),
		.serial_in_pin_in(si), .handshake_port_pin_in(busy),
		.clock_port_out_in(port_cnt[0]), .clock_port_oe_in(port_cnt[1]),
		.so_port_out_in(port_cnt[2]), .so_port_oe_in(port_cnt[3]),
		.irq_ack_in(irq_ack), .pins_out(pins),
		.transfer_done_request_out(done));
	abs_periph u_peer (.sck_in(sck_w), .so_in(so_w), .si_out(si));
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	// Port latches keep moving so the disabled pin path is exercised
	always @(posedge clock_in)
		port_cnt <= port_cnt + 4'h1;
	task automatic complete_run;
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		@(posedge clock_in);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock_in);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		wr_resp = bresp;
	endtask : wr
	task automatic rd(input logic [17:0] a);
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock_in);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd_data = rdata;
		rd_resp = rresp;
	endtask : rd
	task automatic rc(input logic [17:0] a, input logic [7:0] e);
		rd(a);
		chk(rd_data, {24'h000000, e});
	endtask : rc
	function automatic logic [7:0] fix(input logic [7:0] v, input logic r);
		for (int b = 0; b < 8; b++)
			fix[b] = r ? v[7 - b] : v[b];
	endfunction : fix
	task automatic run(input int nb, input logic [7:0] mode, ctrl, intv);
		int n;
		for (int i = 0; i < nb; i++)
			wr(A_RAM + 18'(4 * i), 8'h31 + 8'(i));
		wr(A_PTR, 8'(nb - 1));
		wr(A_MODE, mode);
		wr(A_CTRL, ctrl);
		wr(A_INTV, intv);
		u_peer.bits = 0;
		u_peer.k = 0;
		u_peer.got.delete();
		u_peer.highs.delete();
		wr(A_SHIFT, 8'h55);
		if (mode[5])
			rc(A_CTRL, (ctrl & 8'h82) | 8'h08);
		n = 0;
		do begin
			@(posedge clock_in);
			#1;
			n++;
		end while (done !== 1'b1 && n < 3000);
		chk({31'h0, done}, 32'h1);
		if (mode[5])
			chk(32'($time - 1 - u_peer.t_rise), 32'h20 << mode[1:0]);
		for (int j = 0; j < nb; j++)
			chk({24'h0, u_peer.got[j]}, {24'h0, fix(mode[5] ? 8'h31 + 8'(nb - 1 - j) : 8'h55, mode[6])});
		@(posedge clock_in);
		irq_ack <= 1'b1;
		@(posedge clock_in);
		irq_ack <= 1'b0;
		repeat (3) @(posedge clock_in);
		#1;
		chk({31'h0, done}, 32'h0);
		rc(A_CTRL, ctrl & 8'h82);
		if (mode[5]) begin
			rc(A_PTR, 8'h00);
			for (int i = 0; i < nb; i++)
				rc(A_RAM + 18'(4 * i), ctrl[7] ? fix(8'h1E + 8'(nb - 1 - i), mode[6]) : 8'h31 + 8'(i));
		end
	endtask : run
	initial begin
		#400000;
		miscompares++;
		complete_run;
	end
	initial begin
		{nrst_in, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{irq_ack, busy, port_cnt} = 6'h00;
		{awaddr, araddr, wdata} = 68'h0;
		miscompares = 0;
		tests_run = 0;
		repeat (10) @(posedge clock_in);
		nrst_in <= 1'b1;
		rc(A_MODE, 8'h00);
		rc(A_CTRL, 8'h00);
		rc(A_INTV, 8'h00);
		rc(A_PTR, 8'h00);
		rd(18'h00010);
		chk({rd_resp, rd_data[29:0]}, {`ABS_RESP_SLVERR, 30'h0});
		wr(18'h00010, 8'hFF);
		chk({30'h0, wr_resp}, {30'h0, `ABS_RESP_SLVERR});
		wr(A_CTRL, 8'hFF);
		rc(A_CTRL, 8'h82);
		wr(A_CTRL, 8'h00);
		wr(A_INTV, 8'hFF);
		rc(A_INTV, 8'h9F);
		wr(A_INTV, 8'h00);
		wr(A_MODE, 8'h1F);
		rc(A_MODE, 8'h13);
		repeat (20) @(posedge clock_in);
		// serial clock stays undriven with external clock
		wr(A_MODE, 8'h80);
		repeat (20) @(posedge clock_in);
		run(3, 8'hA1, 8'h80, 8'h00);
		base = u_peer.highs[8];
		for (int i = 0; i < 4; i++) begin
			busy <= (i == 3);
			run(2, 8'hA1, i == 3 ? 8'h82 : 8'h80, intv_tab[i]);
			chk(32'(u_peer.highs[8] - base), 32'(16 * xtra[i]));
		end
		busy <= 1'b0;
		run(2, 8'hE3, 8'h80, 8'h00);
		run(2, 8'hA2, 8'h00, 8'h00);
		run(1, 8'h81, 8'h80, 8'h00);
		complete_run;
	end
endmodule : abs_top_bench
